// >>> rtl/cstc_pkg.sv
// Register map, field positions and clock figures for the clock control block
package cstc_pkg;
  localparam logic [8:0] CSTC_ADDR_CPU_USB_SEL = 9'h030;
  localparam logic [8:0] CSTC_ADDR_IOSC_TRIM   = 9'h034;
  localparam logic [8:0] CSTC_ADDR_XOSC_TRIM   = 9'h035;
  localparam logic [8:0] CSTC_ADDR_SLOW_TRIM   = 9'h036;
  localparam logic [8:0] CSTC_ADDR_RETUNE_CFG  = 9'h039;
  localparam logic [8:0] CSTC_ADDR_PIN_CFG     = 9'h032;
  localparam logic [8:0] CSTC_ADDR_SPEED_SLEEP = 9'h1E0;

  // Writable bit masks; reserved bits read zero
  localparam logic [7:0] CSTC_MASK_CPU_USB_SEL = 8'h61;
  localparam logic [7:0] CSTC_MASK_IOSC_TRIM   = 8'hFF;
  localparam logic [7:0] CSTC_MASK_XOSC_TRIM   = 8'h1D;
  localparam logic [7:0] CSTC_MASK_SLOW_TRIM   = 8'hBF;
  localparam logic [7:0] CSTC_MASK_RETUNE_CFG  = 8'h03;
  localparam logic [7:0] CSTC_MASK_PIN_CFG     = 8'h08;
  localparam logic [7:0] CSTC_MASK_SPEED_SLEEP = 8'h3F;

  localparam logic [7:0] CSTC_RST_ZERO = 8'h00;

  // Field positions
  localparam int CSTC_POS_CPU_SEL      = 0;
  localparam int CSTC_POS_USB_SEL      = 5;
  localparam int CSTC_POS_USB_NODIV    = 6;
  localparam int CSTC_POS_FOFFSET      = 5;
  localparam int CSTC_POS_XGM          = 2;
  localparam int CSTC_POS_XMODE        = 0;
  localparam int CSTC_POS_SLOW_LP      = 7;
  localparam int CSTC_POS_SLOW_BIAS    = 4;
  localparam int CSTC_POS_NO_BUZZ      = 5;
  localparam int CSTC_POS_SLEEP        = 3;
  localparam int CSTC_POS_XOSC_EN      = 3;
  localparam int CSTC_POS_RETUNE_OFF   = 0;
  localparam int CSTC_POS_FINE_ONLY    = 1;

  // Slow oscillator bias codes
  typedef enum logic [1:0] {
    CSTC_BIAS_MID  = 2'b00,
    CSTC_BIAS_HIGH = 2'b01,
    CSTC_BIAS_RSVD = 2'b10,
    CSTC_BIAS_OFF  = 2'b11
  } cstc_bias_t;

  // Processor divider reserved code and the divide mask it selects
  localparam logic [2:0] CSTC_SPD_RSVD = 3'h7;
  localparam logic [6:0] CSTC_DIV_MAX  = 7'h7F;

  // Sleep timer: slow clock is nominally 32768 Hz
  localparam int CSTC_SLOW_HZ = 32768;
  localparam int CSTC_SLEEP_HZ_0 = 512;
  localparam int CSTC_SLEEP_HZ_1 = 64;
  localparam int CSTC_SLEEP_HZ_2 = 8;
  localparam int CSTC_SLEEP_HZ_3 = 1;

  // Fine offset weights in Hz per bit, gain weights in Hz per bit
  localparam int CSTC_FOFF_W0_HZ = 7500;
  localparam int CSTC_GAIN_W0_HZ = 1500;
endpackage : cstc_pkg

// >>> rtl/cstc_divider.sv
// Power-of-two clock enable divider on a selected source strobe
module cstc_divider
  import cstc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       src_tick,
  input  wire logic [6:0] div_mask,
  output logic            out_tick
);
  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic       tick_ff;
  logic       nxt_tick;

  // Mask of ones selects 2^n; terminal count when masked bits all set
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (src_tick) begin
      if ((cnt_ff & div_mask) == div_mask) begin
        nxt_cnt  = 7'h00;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = 7'((cnt_ff & div_mask) + 7'h01);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign out_tick = tick_ff;
endmodule // cstc_divider

// >>> rtl/cstc_top.sv
// Clock source selection, oscillator trim and speed control registers
//
// The address-and-strobe port was chosen for this implementation.
module cstc_top
  import cstc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [8:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       iosc_tick,
  input  wire logic       ext_tick,
  input  wire logic       slow_tick,
  input  wire logic       sleep_req,
  input  wire logic       boot_trim_wr,
  input  wire logic [7:0] boot_iosc_trim,
  input  wire logic [7:0] boot_xosc_trim,
  input  wire logic [7:0] boot_slow_trim,
  output logic            processor_clock,
  output logic            serial_bus_clock,
  output logic            sleep_tick,
  output logic [7:0]      iosc_trim_out,
  output logic            xosc_test_mode,
  output logic [2:0]      xosc_xgm,
  output logic            slow_osc_lp,
  output logic [1:0]      slow_osc_bias,
  output logic            slow_osc_off,
  output logic [3:0]      slow_osc_freq,
  output logic            monitor_force_on,
  output logic            retune_active,
  output logic            retune_fine_only,
  output logic            speed_reserved
);
  logic [7:0] cpu_usb_ff,  nxt_cpu_usb;
  logic [7:0] iosc_ff,     nxt_iosc;
  logic [7:0] xosc_ff,     nxt_xosc;
  logic [7:0] slow_ff,     nxt_slow;
  logic [7:0] retune_ff,   nxt_retune;
  logic [7:0] pin_ff,      nxt_pin;
  logic [7:0] speed_ff,    nxt_speed;
  logic [7:0] rdata_ff,    nxt_rdata;

  // Source strobes are pins from another domain: two flops each
  logic [2:0] src_meta_ff, src_sync_ff;
  logic [2:0] src_prev_ff;
  logic [2:0] src_rise;

  logic       cpu_src_tick;
  logic       usb_src_tick;
  logic [6:0] cpu_mask;
  logic [6:0] usb_mask;
  logic [9:0] sleep_cnt_ff, nxt_sleep_cnt;
  logic [9:0] sleep_lim;
  logic       sleep_tick_ff, nxt_sleep_tick;
  logic       mon_ff,        nxt_mon;
  logic       slow_off_ff,   nxt_slow_off;
  logic       speed_rsvd_ff, nxt_speed_rsvd;
  logic       retune_act_ff, nxt_retune_act;
  logic       cpu_tick;
  logic       usb_tick;

  always_comb begin
    nxt_cpu_usb = cpu_usb_ff;
    nxt_iosc    = iosc_ff;
    nxt_xosc    = xosc_ff;
    nxt_slow    = slow_ff;
    nxt_retune  = retune_ff;
    nxt_pin     = pin_ff;
    nxt_speed   = speed_ff;
    nxt_rdata   = 8'h00;
    // Boot loader writes the factory trims; fine offset forced clear
    if (boot_trim_wr) begin
      nxt_iosc = boot_iosc_trim & 8'h1F;
      nxt_xosc = boot_xosc_trim & CSTC_MASK_XOSC_TRIM;
      nxt_slow = boot_slow_trim & CSTC_MASK_SLOW_TRIM;
    end
    if (reg_wr) begin
      case (reg_addr)
        CSTC_ADDR_CPU_USB_SEL: nxt_cpu_usb = reg_wdata & CSTC_MASK_CPU_USB_SEL;
        CSTC_ADDR_IOSC_TRIM:   nxt_iosc    = reg_wdata & CSTC_MASK_IOSC_TRIM;
        CSTC_ADDR_XOSC_TRIM:   nxt_xosc    = reg_wdata & CSTC_MASK_XOSC_TRIM;
        CSTC_ADDR_SLOW_TRIM:   nxt_slow    = reg_wdata & CSTC_MASK_SLOW_TRIM;
        CSTC_ADDR_RETUNE_CFG:  nxt_retune  = reg_wdata & CSTC_MASK_RETUNE_CFG;
        CSTC_ADDR_PIN_CFG:     nxt_pin     = reg_wdata & CSTC_MASK_PIN_CFG;
        CSTC_ADDR_SPEED_SLEEP: nxt_speed   = reg_wdata & CSTC_MASK_SPEED_SLEEP;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        CSTC_ADDR_CPU_USB_SEL: nxt_rdata = cpu_usb_ff;
        CSTC_ADDR_IOSC_TRIM:   nxt_rdata = iosc_ff;
        CSTC_ADDR_XOSC_TRIM:   nxt_rdata = xosc_ff;
        CSTC_ADDR_SLOW_TRIM:   nxt_rdata = slow_ff;
        CSTC_ADDR_RETUNE_CFG:  nxt_rdata = retune_ff;
        CSTC_ADDR_PIN_CFG:     nxt_rdata = pin_ff;
        CSTC_ADDR_SPEED_SLEEP: nxt_rdata = speed_ff;
        default:               nxt_rdata = 8'h00;
      endcase
    end
  end

  // Trims reset to zero here; silicon leaves them undefined until boot
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_usb_ff <= CSTC_RST_ZERO;
      iosc_ff    <= CSTC_RST_ZERO;
      xosc_ff    <= CSTC_RST_ZERO;
      slow_ff    <= CSTC_RST_ZERO;
      retune_ff  <= CSTC_RST_ZERO;
      pin_ff     <= CSTC_RST_ZERO;
      speed_ff   <= CSTC_RST_ZERO;
      rdata_ff   <= 8'h00;
    end else begin
      cpu_usb_ff <= nxt_cpu_usb;
      iosc_ff    <= nxt_iosc;
      xosc_ff    <= nxt_xosc;
      slow_ff    <= nxt_slow;
      retune_ff  <= nxt_retune;
      pin_ff     <= nxt_pin;
      speed_ff   <= nxt_speed;
      rdata_ff   <= nxt_rdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_meta_ff <= 3'h0;
      src_sync_ff <= 3'h0;
      src_prev_ff <= 3'h0;
    end else begin
      src_meta_ff <= {slow_tick, ext_tick, iosc_tick};
      src_sync_ff <= src_meta_ff;
      src_prev_ff <= src_sync_ff;
    end
  end

  assign src_rise = src_sync_ff & ~src_prev_ff;

  // External path: crystal if enabled, else the input pin; both arrive
  // on ext_tick since the pad mux sits outside this block
  always_comb begin
    cpu_src_tick = cpu_usb_ff[CSTC_POS_CPU_SEL] ? src_rise[1]
                                                : src_rise[0];
    usb_src_tick = cpu_usb_ff[CSTC_POS_USB_SEL] ? src_rise[1]
                                                : src_rise[0];
  end

  // Speed code to divide mask; reserved code holds the slowest rate
  always_comb begin
    case (speed_ff[2:0])
      3'h0:    cpu_mask = 7'h07;
      3'h1:    cpu_mask = 7'h03;
      3'h2:    cpu_mask = 7'h01;
      3'h3:    cpu_mask = 7'h00;
      3'h4:    cpu_mask = 7'h0F;
      3'h5:    cpu_mask = 7'h1F;
      3'h6:    cpu_mask = 7'h7F;
      default: cpu_mask = CSTC_DIV_MAX;
    endcase
  end

  // Internal source always halved; external halved unless bypassed
  always_comb begin
    if (cpu_usb_ff[CSTC_POS_USB_SEL] && cpu_usb_ff[CSTC_POS_USB_NODIV]) begin
      usb_mask = 7'h00;
    end else begin
      usb_mask = 7'h01;
    end
  end

  cstc_divider u_cpu_div (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .src_tick (cpu_src_tick),
    .div_mask (cpu_mask),
    .out_tick (cpu_tick)
  );

  cstc_divider u_usb_div (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .src_tick (usb_src_tick),
    .div_mask (usb_mask),
    .out_tick (usb_tick)
  );

  // Sleep timer divides the slow oscillator to 512, 64, 8 or 1 Hz
  always_comb begin
    case (speed_ff[4:3])
      2'h0:    sleep_lim = 10'(CSTC_SLOW_HZ / CSTC_SLEEP_HZ_0 - 1);
      2'h1:    sleep_lim = 10'(CSTC_SLOW_HZ / CSTC_SLEEP_HZ_1 / 8 - 1);
      2'h2:    sleep_lim = 10'(CSTC_SLOW_HZ / CSTC_SLEEP_HZ_2 / 64 - 1);
      default: sleep_lim = 10'(CSTC_SLOW_HZ / CSTC_SLEEP_HZ_3 / 512 - 1);
    endcase
  end

  // Coarse counter reaches 1/64 of the slow rate; a count of 4096
  // or 32768 would need more than its 10 flops, so long periods step in groups
  logic [8:0] sleep_pre_ff, nxt_sleep_pre;
  logic [8:0] pre_lim;
  always_comb begin
    case (speed_ff[4:3])
      2'h0:    pre_lim = 9'h000;
      2'h1:    pre_lim = 9'h007;
      2'h2:    pre_lim = 9'h03F;
      default: pre_lim = 9'h1FF;
    endcase
  end

  always_comb begin
    nxt_sleep_pre  = sleep_pre_ff;
    nxt_sleep_cnt  = sleep_cnt_ff;
    nxt_sleep_tick = 1'b0;
    if (src_rise[2] && !slow_osc_off) begin
      if (sleep_pre_ff >= pre_lim) begin
        nxt_sleep_pre = 9'h000;
        if (sleep_cnt_ff >= sleep_lim) begin
          nxt_sleep_cnt  = 10'h000;
          nxt_sleep_tick = 1'b1;
        end else begin
          nxt_sleep_cnt = 10'(sleep_cnt_ff + 10'h001);
        end
      end else begin
        nxt_sleep_pre = 9'(sleep_pre_ff + 9'h001);
      end
    end
  end

  always_comb begin
    nxt_mon        = sleep_req & speed_ff[CSTC_POS_NO_BUZZ];
    nxt_retune_act = ~cpu_usb_ff[CSTC_POS_USB_SEL] &
                     ~retune_ff[CSTC_POS_RETUNE_OFF];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_pre_ff  <= 9'h000;
      sleep_cnt_ff  <= 10'h000;
      sleep_tick_ff <= 1'b0;
      mon_ff        <= 1'b0;
      retune_act_ff <= 1'b0;
    end else begin
      sleep_pre_ff  <= nxt_sleep_pre;
      sleep_cnt_ff  <= nxt_sleep_cnt;
      sleep_tick_ff <= nxt_sleep_tick;
      mon_ff        <= nxt_mon;
      retune_act_ff <= nxt_retune_act;
    end
  end

  // Flags decode the next state so they stay in step with their fields
  // yet still leave the block from a flop
  always_comb begin
    nxt_slow_off   = nxt_slow[CSTC_POS_SLOW_BIAS +: 2] == CSTC_BIAS_OFF;
    nxt_speed_rsvd = nxt_speed[2:0] == CSTC_SPD_RSVD;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      slow_off_ff   <= 1'b0;
      speed_rsvd_ff <= 1'b0;
    end else begin
      slow_off_ff   <= nxt_slow_off;
      speed_rsvd_ff <= nxt_speed_rsvd;
    end
  end

  // Trim fields drive the analog oscillators straight from their flops
  assign iosc_trim_out    = iosc_ff;
  assign xosc_test_mode   = xosc_ff[CSTC_POS_XMODE];
  assign xosc_xgm         = xosc_ff[CSTC_POS_XGM +: 3];
  assign slow_osc_lp      = slow_ff[CSTC_POS_SLOW_LP];
  assign slow_osc_bias    = slow_ff[CSTC_POS_SLOW_BIAS +: 2];
  assign slow_osc_off     = slow_off_ff;
  assign slow_osc_freq    = slow_ff[3:0];
  assign retune_fine_only = retune_ff[CSTC_POS_FINE_ONLY];
  assign speed_reserved   = speed_rsvd_ff;
  assign processor_clock  = cpu_tick;
  assign serial_bus_clock = usb_tick;
  assign sleep_tick       = sleep_tick_ff;
  assign monitor_force_on = mon_ff;
  assign retune_active    = retune_act_ff;
  assign reg_rdata        = rdata_ff;
endmodule // cstc_top

// >>> verif/cstc_props.sv
// Checker of register and control outputs of the clock control block
module cstc_props
  import cstc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sleep_req,
  input wire logic       boot_trim_wr,
  input wire logic       serial_bus_clock,
  input wire logic [7:0] iosc_trim_out,
  input wire logic       xosc_test_mode,
  input wire logic       slow_osc_lp,
  input wire logic [1:0] slow_osc_bias,
  input wire logic       slow_osc_off,
  input wire logic [3:0] slow_osc_freq,
  input wire logic       monitor_force_on,
  input wire logic       retune_active,
  input wire logic       speed_reserved
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic wr_i, wr_x, wr_s, wr_p, wr_c;
  assign wr_i = reg_wr && reg_addr == CSTC_ADDR_IOSC_TRIM;
  assign wr_x = reg_wr && reg_addr == CSTC_ADDR_XOSC_TRIM;
  assign wr_s = reg_wr && reg_addr == CSTC_ADDR_SLOW_TRIM;
  assign wr_p = reg_wr && reg_addr == CSTC_ADDR_SPEED_SLEEP;
  assign wr_c = reg_wr && reg_addr == CSTC_ADDR_CPU_USB_SEL;
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  AST_IOSC_WR: assert property (
    wr_i |=> iosc_trim_out == $past(reg_wdata))
    else $error("internal trim not taken from write");
  AST_BOOT_FOFF: assert property (
    boot_trim_wr && !wr_i |=> iosc_trim_out[7:5] == 3'h0)
    else $error("boot load left a fine offset");
  AST_XMODE: assert property (
    wr_x |=> xosc_test_mode == $past(reg_wdata[0]))
    else $error("crystal mode bit wrong");
  AST_SLOW_WR: assert property (
    wr_s |=> slow_osc_lp == $past(reg_wdata[7])
    && slow_osc_freq == $past(reg_wdata[3:0])
    && slow_osc_bias == $past(reg_wdata[5:4]))
    else $error("slow trim fields wrong");
  AST_SLOW_OFF: assert property (slow_osc_off == (slow_osc_bias == 2'h3))
    else $error("slow oscillator off decode wrong");
  AST_MON_SLEEP: assert property (!sleep_req |=> !monitor_force_on)
    else $error("monitor forced on while awake");
  AST_SPEED_RSVD: assert property (wr_p |=>
    speed_reserved == ($past(reg_wdata[2:0]) == CSTC_SPD_RSVD))
    else $error("reserved speed flag wrong");
  AST_RETUNE_EXT: assert property (
    wr_c && reg_wdata[5] |-> ##2 !retune_active)
    else $error("retune active with external source");
  AST_USB_PULSE: assert property (serial_bus_clock |=> !serial_bus_clock)
    else $error("serial clock pulse too long");
endmodule // cstc_props

bind cstc_top cstc_props i_props (.*);

// >>> verif/cstc_xtal_model.sv
// Behavioural external oscillator feeding the external clock input
module cstc_xtal_model (
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic [3:0] half,
  output logic            ext_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff, nxt_cnt;
  logic       tick_ff, nxt_tick;
  // A stopped source rests low instead of holding its last level
  always_comb begin
    nxt_cnt  = cnt_ff + 4'h1;
    nxt_tick = tick_ff;
    if (!run) begin
      nxt_cnt  = 4'h0;
      nxt_tick = 1'b0;
    end else if (nxt_cnt >= half) begin
      nxt_cnt  = 4'h0;
      nxt_tick = ~tick_ff;
    end
  end
  always_ff @(posedge mclk) begin
    cnt_ff  <= nxt_cnt;
    tick_ff <= nxt_tick;
  end
  assign ext_tick = tick_ff;
endmodule // cstc_xtal_model

// >>> verif/clock_source_and_trim_control_tb.sv
// Self-checking bench for the clock control block
module clock_source_and_trim_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cstc_pkg::*;
  localparam logic [8:0] ADRS [7] = '{CSTC_ADDR_CPU_USB_SEL,
    CSTC_ADDR_IOSC_TRIM, CSTC_ADDR_XOSC_TRIM, CSTC_ADDR_SLOW_TRIM,
    CSTC_ADDR_RETUNE_CFG, CSTC_ADDR_PIN_CFG, CSTC_ADDR_SPEED_SLEEP};
  localparam int DIV [8] = '{8, 4, 2, 1, 16, 32, 128, 128};
  localparam int SLP [4] = '{256, 2048, 16384, 2048};
  localparam int USB [4] = '{60, 40, 60, 80};
  logic       mclk, rst_b, reg_wr, reg_rd, sleep_req, boot_trim_wr;
  logic       iosc_tick, ext_tick, slow_tick, xrun, slow_run;
  logic       processor_clock, serial_bus_clock, sleep_tick;
  logic       xosc_test_mode, slow_osc_lp, slow_osc_off, monitor_force_on;
  logic       retune_active, retune_fine_only, speed_reserved;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, iosc_trim_out, d, rv;
  logic [7:0] boot_iosc_trim, boot_xosc_trim, boot_slow_trim;
  logic [2:0] xosc_xgm, ph;
  logic [1:0] slow_osc_bias;
  logic [3:0] slow_osc_freq, xhalf;
  int         bad_count, num_checks, np, ns, nt, mdl [0:511];
  cstc_top i_dut (.*);
  cstc_xtal_model i_xtal (.mclk(mclk), .run(xrun), .half(xhalf),
    .ext_tick(ext_tick));
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    ph <= ph + 3'h1;
    iosc_tick <= ph[1];
    slow_tick <= ph[0] & slow_run;
  end
  function automatic int msk(input logic [8:0] a);
    for (int i = 0; i < 7; i++)
      if (ADRS[i] == a) return mk(i);
    return 0;
  endfunction
  function automatic int mk(input int i);
    logic [7:0] m [7] = '{CSTC_MASK_CPU_USB_SEL, CSTC_MASK_IOSC_TRIM,
      CSTC_MASK_XOSC_TRIM, CSTC_MASK_SLOW_TRIM, CSTC_MASK_RETUNE_CFG,
      CSTC_MASK_PIN_CFG, CSTC_MASK_SPEED_SLEEP};
    return int'(m[i]);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  function automatic logic near(input int n, input int e);
    return n >= e - 1 && n <= e + 1;
  endfunction
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    mdl[a] = int'(v) & msk(a);
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(reg_rdata, mdl[a]);
  endtask
  task automatic outs;
    #1;
    chk(iosc_trim_out, mdl[CSTC_ADDR_IOSC_TRIM]);
    chk(xosc_test_mode, mdl[CSTC_ADDR_XOSC_TRIM] & 1);
    chk(xosc_xgm, mdl[CSTC_ADDR_XOSC_TRIM] >> 2 & 7);
    chk(slow_osc_lp, mdl[CSTC_ADDR_SLOW_TRIM] >> 7 & 1);
    chk(slow_osc_bias, mdl[CSTC_ADDR_SLOW_TRIM] >> 4 & 3);
    chk(slow_osc_off, (mdl[CSTC_ADDR_SLOW_TRIM] >> 4 & 3) == 3);
    chk(slow_osc_freq, mdl[CSTC_ADDR_SLOW_TRIM] & 15);
    chk(retune_fine_only, mdl[CSTC_ADDR_RETUNE_CFG] >> 1 & 1);
  endtask
  task automatic run(input int cyc);
    np = 0;
    ns = 0;
    nt = 0;
    repeat (cyc) begin
      @(posedge mclk);
      #1 np += processor_clock;
      ns += serial_bus_clock;
      nt += sleep_tick;
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    give_verdict();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, sleep_req, boot_trim_wr, xrun, slow_run} = '0;
    {reg_addr, reg_wdata, ph, iosc_tick, slow_tick} = '0;
    {boot_iosc_trim, boot_xosc_trim, boot_slow_trim} = '0;
    xhalf = 4'h3;
    foreach (mdl[i]) mdl[i] = 0;
    np = $urandom(11);
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (ADRS[i]) rd(ADRS[i]);
    rd(9'h1FF);
    repeat (3) foreach (ADRS[i]) begin
      d = 8'($urandom);
      // Bias code 10 may stall the slow oscillator, so software avoids it
      if (ADRS[i] == CSTC_ADDR_SLOW_TRIM && d[5:4] == 2'h2) d[5] = 1'b0;
      wr(ADRS[i], d);
      rd(ADRS[i]);
      outs();
    end
    wr(9'h1FF, 8'hFF);
    rd(9'h1FF);
    for (int i = 0; i < 3; i++) begin
      wr(CSTC_ADDR_XOSC_TRIM, 8'({(3'h7 >> (2 - i)), 1'b0, i[0]}));
      outs();
      rd(CSTC_ADDR_SLOW_TRIM);
      wr(CSTC_ADDR_SLOW_TRIM, {~rv[7], rv[6], 2'(i * 3 / 2), rv[3:0]});
      outs();
    end
    @(posedge mclk);
    boot_iosc_trim <= 8'($urandom);
    boot_xosc_trim <= 8'($urandom);
    boot_slow_trim <= 8'($urandom);
    boot_trim_wr <= 1'b1;
    @(posedge mclk);
    boot_trim_wr <= 1'b0;
    mdl[CSTC_ADDR_IOSC_TRIM] = int'(boot_iosc_trim) & 32'h1F;
    mdl[CSTC_ADDR_XOSC_TRIM] = int'(boot_xosc_trim) & 32'h1D;
    mdl[CSTC_ADDR_SLOW_TRIM] = int'(boot_slow_trim) & 32'hBF;
    foreach (ADRS[i]) rd(ADRS[i]);
    outs();
    wr(CSTC_ADDR_CPU_USB_SEL, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(CSTC_ADDR_SPEED_SLEEP, 8'(c));
      run(2048);
      chk(near(np, 512 / DIV[c]), 1'b1);
      chk(speed_reserved, c == 7);
    end
    wr(CSTC_ADDR_SPEED_SLEEP, 8'h03);
    wr(CSTC_ADDR_RETUNE_CFG, 8'h00);
    xrun <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(CSTC_ADDR_CPU_USB_SEL, {1'b0, k[1], k[0], 4'h0, k[0]});
      run(480);
      chk(near(ns, USB[k]), 1'b1);
      chk(near(np, k[0] ? 80 : 120), 1'b1);
      chk(retune_active, !k[0]);
    end
    xrun <= 1'b0;
    slow_run <= 1'b1;
    wr(CSTC_ADDR_SLOW_TRIM, 8'h05);
    for (int s = 0; s < 4; s++) begin
      wr(CSTC_ADDR_SPEED_SLEEP, 8'(s << 3));
      run(SLP[s]);
      chk(near(nt, s == 3 ? 0 : 2), 1'b1);
    end
    wr(CSTC_ADDR_SPEED_SLEEP, 8'h00);
    wr(CSTC_ADDR_SLOW_TRIM, 8'h35);
    run(512);
    chk(nt, 0);
    wr(CSTC_ADDR_SPEED_SLEEP, 8'h20);
    run(3);
    chk(monitor_force_on, 1'b0);
    @(posedge mclk);
    sleep_req <= 1'b1;
    run(3);
    chk(monitor_force_on, 1'b1);
    wr(CSTC_ADDR_SPEED_SLEEP, 8'h00);
    run(3);
    chk(monitor_force_on, 1'b0);
    @(posedge mclk);
    sleep_req <= 1'b0;
    rd(CSTC_ADDR_SPEED_SLEEP);
    give_verdict();
  end
endmodule // clock_source_and_trim_control_tb
